/* File: verilog/xcvr_pkg.sv */
// Purpose: shared constants and types for the registered backplane transceiver
// Assumes: one 25 MHz system clock; all pins arrive asynchronously
// Notes: mode codes follow the two-bit select pins of each direction
package xcvr_pkg;

    // Data path
    localparam int DATA_W = 8;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Mode select codes, upper bit set means latch whatever the lower bit
    localparam logic [1:0] MODE_BUF = 2'h0;
    localparam logic [1:0] MODE_FF = 2'h1;
    localparam int MODE_HI_BIT = 1;

    // Pin synchroniser depth and its filtered-output reset value
    localparam int SYNC_STAGES = 3;
    localparam logic SYNC_RST = 1'h0;

    // Capture FIFO
    localparam int CAP_DEPTH = 8;

    // Clock figures, kept for latency bookkeeping
    localparam int CLK_PERIOD_NS = 40;
    localparam int PIN_LATENCY_CYCLES = 6;

    // One-hot logic element type of a direction
    typedef enum logic [2:0] {
        ELEM_BUF = 3'h1,
        ELEM_FF = 3'h2,
        ELEM_LATCH = 3'h4
    } elem_t;

    // Decode of a two-bit mode select into an element type
    function automatic elem_t decode_mode(input logic [1:0] sel);
        elem_t e;
        e = ELEM_BUF;
        if (sel[MODE_HI_BIT]) begin
            e = ELEM_LATCH;
        end else if (sel == MODE_FF) begin
            e = ELEM_FF;
        end
        return e;
    endfunction

endpackage

/* File: verilog/pin_sync.sv */
// Purpose: three-flop synchroniser with agreement filter for pin inputs
// Assumes: pins are asynchronous to SYS_CLK
// Notes: filtered bit moves only when stages two and three agree
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic [WIDTH-1:0] pin, // Raw asynchronous pins
    output logic [WIDTH-1:0] filt // Synchronised, filtered value
);
    import xcvr_pkg::*;

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    // Shift chain; s1 feeds only s2 to keep metastability contained
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else if (ce) begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Per-bit agreement filter rejects single-cycle glitches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt <= {WIDTH{SYNC_RST}};
        end else if (ce) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    filt[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule

/* File: verilog/cap_fifo.sv */
// Purpose: small FIFO with registered output stage for the capture stream
// Assumes: single clock; a push while in_ready is low is dropped
// Notes: holds DEPTH words in the array plus one in the output stage
module cap_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic in_valid, // Push request
    input wire logic [WIDTH-1:0] in_data, // Push data
    output logic in_ready, // Room for a push, registered
    output logic out_valid, // Output word present, registered
    output logic [WIDTH-1:0] out_data, // Output word, registered
    input wire logic out_ready // Consumer takes the output word
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic [PW:0] count_next;
    logic push;
    logic pop;

    // Pop moves a word into the output stage when it is empty or being taken
    assign push = in_valid && in_ready;
    assign pop = (count_reg != '0) && (!out_valid || out_ready);

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Storage array and pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready <= 1'b1;
        end else if (ce) begin
            if (push) begin
                wr_ptr_reg <= PW'((wr_ptr_reg + 1'b1) % DEPTH);
            end
            if (pop) begin
                rd_ptr_reg <= PW'((rd_ptr_reg + 1'b1) % DEPTH);
            end
            count_reg <= count_next;
            in_ready <= (count_next != (PW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Registered output stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (ce) begin
            if (pop) begin
                out_valid <= 1'b1;
                out_data <= mem[rd_ptr_reg];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

endmodule

/* File: verilog/backplane_xcvr.sv */
// Purpose: eight-bit inverting registered transceiver, card port to backplane
// Assumes: every pin input is asynchronous and passes a three-flop filter
// Notes: buffer mode is a per-cycle copy, so all paths carry pin latency
// Notes: backplane is open drain; a bit is pulled low only while driving
// How it works
// - Eight bits each way, both paths inverted
// - Separate two-bit mode select per direction
// - 00 buffer, 01 flip-flop, 1x latch
// - Buffer mode passes inverted input straight through
// - Flip-flop captures on its direction clock rise
// - Latch transparent while its enable high
// - Feedback low: backplane feeds receive element
// - Feedback high: transmit element feeds receive
// - Card output floats when its enable low
// - Card output drives when its enable high
// - Backplane drives only enable high, low-enable low
// - Elements keep capturing while outputs disabled
// - Disabled elements retain stored data too
module backplane_xcvr #(
    parameter int WIDTH = xcvr_pkg::DATA_W,
    parameter int FIFO_DEPTH = xcvr_pkg::CAP_DEPTH
) (
    input wire logic SYS_CLK, // 25 MHz system clock
    input wire logic RESET_N, // Asynchronous reset, active low
    input wire logic CLK_EN, // Clock enable, freezes all state
    input wire logic [WIDTH-1:0] CARD_DATA_IN, // Card-side input data
    output logic [WIDTH-1:0] CARD_DATA_OUT, // Card-side output data
    output logic CARD_DATA_OUT_OE, // Card output enable, high drives
    input wire logic [WIDTH-1:0] BP_DATA_IN, // Backplane wire level
    output logic [WIDTH-1:0] BP_DATA_OUT, // Backplane drive level, always low
    output logic [WIDTH-1:0] BP_DATA_OE, // Backplane pull-down enable per bit
    input wire logic RX_MODE_SEL_HI, // Receive mode select, upper bit
    input wire logic RX_MODE_SEL_LO, // Receive mode select, lower bit
    input wire logic TX_MODE_SEL_HI, // Transmit mode select, upper bit
    input wire logic TX_MODE_SEL_LO, // Transmit mode select, lower bit
    input wire logic A2B_CLOCK_ENABLE, // Transmit clock or latch enable
    input wire logic B2A_CLOCK_ENABLE, // Receive clock or latch enable
    input wire logic FEEDBACK_SELECT, // Route transmit element to receive
    input wire logic A_OUT_ENABLE, // Card output enable
    input wire logic B_OUT_ENABLE, // Backplane enable, active high
    input wire logic B_OUT_ENABLE_LOW, // Backplane enable, active low
    input wire logic EDGE_RATE_SELECT, // High selects slow backplane edges
    output logic EDGE_RATE_SLOW, // Slew control to the pad, high slow
    output logic [WIDTH-1:0] CAPTURE_DATA, // Receive element history word
    output logic CAPTURE_VALID, // History word present
    input wire logic CAPTURE_READY, // Consumer takes history word
    output logic CAPTURE_SPACE // History FIFO can accept a word
);
    import xcvr_pkg::*;

    localparam int NSYNC = 2 * WIDTH + 11;

    // Filtered pin values
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] pins_filt;
    logic [WIDTH-1:0] card_in_f;
    logic [WIDTH-1:0] bp_in_f;
    logic [1:0] rx_sel_f;
    logic [1:0] tx_sel_f;
    logic a2b_en_f;
    logic b2a_en_f;
    logic fb_f;
    logic a_oe_f;
    logic b_oe_f;
    logic b_oe_low_f;
    logic erc_f;

    // Element state and edge history
    elem_t tx_elem;
    elem_t rx_elem;
    logic a2b_en_prev_reg;
    logic b2a_en_prev_reg;
    logic a2b_rise;
    logic b2a_rise;
    logic [WIDTH-1:0] a2b_reg;
    logic [WIDTH-1:0] a2b_next;
    logic [WIDTH-1:0] b2a_reg;
    logic [WIDTH-1:0] b2a_next;
    logic [WIDTH-1:0] rx_src;
    logic b_drive;
    logic cap_push;

    // All pin inputs go through one filter bank
    assign pins_raw = {CARD_DATA_IN, BP_DATA_IN, RX_MODE_SEL_HI, RX_MODE_SEL_LO,
                       TX_MODE_SEL_HI, TX_MODE_SEL_LO, A2B_CLOCK_ENABLE,
                       B2A_CLOCK_ENABLE, FEEDBACK_SELECT, A_OUT_ENABLE,
                       B_OUT_ENABLE, B_OUT_ENABLE_LOW, EDGE_RATE_SELECT};

    pin_sync #(
        .WIDTH(NSYNC)
    ) u_pin_sync (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .ce(CLK_EN),
        .pin(pins_raw),
        .filt(pins_filt)
    );

    assign {card_in_f, bp_in_f, rx_sel_f, tx_sel_f, a2b_en_f, b2a_en_f, fb_f,
            a_oe_f, b_oe_f, b_oe_low_f, erc_f} = pins_filt;

    // Mode decode per direction
    assign tx_elem = decode_mode(tx_sel_f);
    assign rx_elem = decode_mode(rx_sel_f);

    // Rising edges of the filtered direction clocks
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            a2b_en_prev_reg <= 1'b0;
            b2a_en_prev_reg <= 1'b0;
        end else if (CLK_EN) begin
            a2b_en_prev_reg <= a2b_en_f;
            b2a_en_prev_reg <= b2a_en_f;
        end
    end

    assign a2b_rise = a2b_en_f && !a2b_en_prev_reg;
    assign b2a_rise = b2a_en_f && !b2a_en_prev_reg;

    // Transmit element: stored value is the non-inverted point feeding back
    always_comb begin
        a2b_next = a2b_reg;
        case (tx_elem)
            ELEM_BUF: begin
                a2b_next = card_in_f;
            end
            ELEM_FF: begin
                if (a2b_rise) begin
                    a2b_next = card_in_f;
                end
            end
            ELEM_LATCH: begin
                if (a2b_en_f) begin
                    a2b_next = card_in_f;
                end
            end
            default: begin
                a2b_next = a2b_reg;
            end
        endcase
    end

    // Element runs whatever the output enables say
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            a2b_reg <= DATA_RST;
        end else if (CLK_EN) begin
            a2b_reg <= a2b_next;
        end
    end

    // Receive source: backplane, or the transmit element's stored data.
    // Feedback is taken inverted so the card port echoes card input as is.
    assign rx_src = fb_f ? ~a2b_reg : bp_in_f;

    // Receive element
    always_comb begin
        b2a_next = b2a_reg;
        case (rx_elem)
            ELEM_BUF: begin
                b2a_next = rx_src;
            end
            ELEM_FF: begin
                if (b2a_rise) begin
                    b2a_next = rx_src;
                end
            end
            ELEM_LATCH: begin
                if (b2a_en_f) begin
                    b2a_next = rx_src;
                end
            end
            default: begin
                b2a_next = b2a_reg;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            b2a_reg <= DATA_RST;
        end else if (CLK_EN) begin
            b2a_reg <= b2a_next;
        end
    end

    // Card port: inverted receive element, tristate by its enable
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CARD_DATA_OUT <= ~DATA_RST;
            CARD_DATA_OUT_OE <= 1'b0;
        end else if (CLK_EN) begin
            CARD_DATA_OUT <= ~b2a_reg;
            CARD_DATA_OUT_OE <= a_oe_f;
        end
    end

    // Backplane driver needs both enables agreeing
    assign b_drive = b_oe_f && !b_oe_low_f;

    // Open drain: inverted data low means pull down, so pull where stored bit is 1
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            BP_DATA_OUT <= '0;
            BP_DATA_OE <= '0;
        end else if (CLK_EN) begin
            BP_DATA_OUT <= '0;
            BP_DATA_OE <= b_drive ? a2b_reg : '0;
        end
    end

    // Slew control is passed through; it never touches data
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            EDGE_RATE_SLOW <= 1'b0;
        end else if (CLK_EN) begin
            EDGE_RATE_SLOW <= erc_f;
        end
    end

    // History of receive element changes; a word is dropped when full,
    // since the element itself must never stall on a monitor
    assign cap_push = (b2a_next != b2a_reg);

    cap_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_cap_fifo (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .ce(CLK_EN),
        .in_valid(cap_push),
        .in_data(b2a_next),
        .in_ready(CAPTURE_SPACE),
        .out_valid(CAPTURE_VALID),
        .out_data(CAPTURE_DATA),
        .out_ready(CAPTURE_READY)
    );

    // Checks on the element behaviour and the output stages
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    AST_CARD_INVERT: assert property (
        CLK_EN |=> CARD_DATA_OUT == ~$past(b2a_reg))
        else $error("card output is not the inverted receive element");

    AST_TX_BUFFER: assert property (
        (CLK_EN && tx_sel_f == MODE_BUF) |=> a2b_reg == $past(card_in_f))
        else $error("transmit buffer did not follow card input");

    AST_TX_FF_CAPTURE: assert property (
        (CLK_EN && tx_sel_f == MODE_FF && a2b_en_f && !a2b_en_prev_reg)
            |=> a2b_reg == $past(card_in_f))
        else $error("transmit flip-flop missed a rising edge");

    AST_RX_FF_HOLD: assert property (
        (CLK_EN && rx_sel_f == MODE_FF && !(b2a_en_f && !b2a_en_prev_reg))
            |=> $stable(b2a_reg))
        else $error("receive flip-flop changed without a rising edge");

    AST_TX_LATCH_OPEN: assert property (
        (CLK_EN && tx_sel_f[MODE_HI_BIT] && a2b_en_f) |=> a2b_reg == $past(card_in_f))
        else $error("transmit latch not transparent while enabled");

    AST_RX_LATCH_HOLD: assert property (
        (CLK_EN && rx_sel_f[MODE_HI_BIT] && !b2a_en_f) |=> $stable(b2a_reg))
        else $error("receive latch changed while closed");

    AST_RX_FROM_BP: assert property (
        (CLK_EN && !fb_f && rx_sel_f == MODE_BUF) |=> b2a_reg == $past(bp_in_f))
        else $error("receive buffer did not take backplane data");

    AST_RX_FEEDBACK: assert property (
        (CLK_EN && fb_f && rx_sel_f == MODE_BUF) |=> b2a_reg == ~$past(a2b_reg))
        else $error("feedback path did not reach receive element");

    AST_CARD_OE: assert property (
        CLK_EN |=> CARD_DATA_OUT_OE == $past(a_oe_f))
        else $error("card output enable does not follow its control");

    AST_BP_QUIET: assert property (
        (CLK_EN && (!b_oe_f || b_oe_low_f)) |=> BP_DATA_OE == '0)
        else $error("backplane driven while disabled");

    AST_BP_DRIVE: assert property (
        (CLK_EN && b_oe_f && !b_oe_low_f) |=> BP_DATA_OE == $past(a2b_reg))
        else $error("backplane pull-downs do not match inverted data");

    AST_HIDDEN_CAPTURE: assert property (
        (CLK_EN && !b_oe_f && tx_sel_f[MODE_HI_BIT] && a2b_en_f) ##1
        (CLK_EN && !b_oe_f) |=> a2b_reg == $past(card_in_f, 2) || $past(a2b_en_f))
        else $error("disabled element stopped capturing");

    AST_FREEZE: assert property (
        !CLK_EN |=> $stable(a2b_reg) && $stable(b2a_reg) && $stable(CARD_DATA_OUT))
        else $error("state moved while clock enable low");

    AST_RX_FF_CAPTURE: assert property (
        (CLK_EN && rx_sel_f == MODE_FF && b2a_en_f && !b2a_en_prev_reg)
            |=> b2a_reg == $past(rx_src))
        else $error("receive flip-flop missed a rising edge");

    AST_TX_FF_HOLD: assert property (
        (CLK_EN && tx_sel_f == MODE_FF && !(a2b_en_f && !a2b_en_prev_reg))
            |=> $stable(a2b_reg))
        else $error("transmit flip-flop changed without a rising edge");

    AST_RX_LATCH_OPEN: assert property (
        (CLK_EN && rx_sel_f[MODE_HI_BIT] && b2a_en_f) |=> b2a_reg == $past(rx_src))
        else $error("receive latch not transparent while enabled");

    AST_TX_LATCH_HOLD: assert property (
        (CLK_EN && tx_sel_f[MODE_HI_BIT] && !a2b_en_f) |=> $stable(a2b_reg))
        else $error("transmit latch changed while closed");

    AST_CARD_DRIVES: assert property (
        (CLK_EN && a_oe_f) |=> CARD_DATA_OUT_OE)
        else $error("card output not driven while enabled");

    AST_RX_FF_FEEDBACK: assert property (
        (CLK_EN && fb_f && rx_sel_f == MODE_FF && b2a_en_f && !b2a_en_prev_reg)
            |=> b2a_reg == ~$past(a2b_reg))
        else $error("feedback path did not reach receive flip-flop");

    AST_RX_FF_FROM_BP: assert property (
        (CLK_EN && !fb_f && rx_sel_f == MODE_FF && b2a_en_f && !b2a_en_prev_reg)
            |=> b2a_reg == $past(bp_in_f))
        else $error("receive flip-flop did not take backplane data");

    // A waiting history word must stand until the consumer takes it
    AST_CAPTURE_HOLD: assert property (
        (CLK_EN && CAPTURE_VALID && !CAPTURE_READY)
            |=> CAPTURE_VALID && $stable(CAPTURE_DATA))
        else $error("history word changed before it was taken");

    COV_FF_CAPTURE: cover property (
        CLK_EN && tx_sel_f == MODE_FF && a2b_en_f && !a2b_en_prev_reg);
    COV_FEEDBACK_LATCH: cover property (
        CLK_EN && fb_f && rx_sel_f[MODE_HI_BIT] && b2a_en_f);
    COV_DISABLED_CAPTURE: cover property (
        CLK_EN && !a_oe_f && rx_sel_f == MODE_FF && b2a_en_f && !b2a_en_prev_reg);
    COV_FIFO_FULL: cover property (!CAPTURE_SPACE);

endmodule

/* File: dv/bp_bus_model.sv */
// Purpose: shared open-drain backplane as seen from one card slot
// Assumes: every wire has a pull-up and any party may pull it low
// Notes: a released wire reads high, never its last driven value
module bp_bus_model #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] drv_level, // Level the transceiver drives
    input wire logic [WIDTH-1:0] drv_oe, // Transceiver pull-down enables
    input wire logic [WIDTH-1:0] other_pull, // Other cards pulling low
    output logic [WIDTH-1:0] wire_level // Resolved backplane level
);
    timeunit 1ns;
    timeprecision 100ps;

    // Wired-AND with pull-up; a driven one counts as released
    always_comb begin
        wire_level = ~((drv_oe & ~drv_level) | other_pull);
    end
endmodule

/* File: dv/tb.sv */
// Purpose: self-checking bench for the backplane transceiver
// Assumes: 25 MHz clock, inputs driven 1 ns after each rising edge
// Notes: checks wait out pin latency, twice over for the wire loop, except the drain and reset checks
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import xcvr_pkg::*;

    // Long enough for card to wire and wire back to card
    localparam int LAT = 16;

    typedef struct packed {
        logic [7:0] din;
        logic [7:0] pull;
        logic [1:0] txm;
        logic [1:0] rxm;
        logic a2b, b2a, fb, aoe, boe, boel, ers;
        logic [7:0] dout;
        logic oe;
        logic [7:0] bpoe;
        logic slow;
    } row_t;

    // din pull txm rxm a2b b2a fb aoe boe boel ers | dout oe bpoe slow
    row_t rows [6] = '{
        '{8'hA5, 8'h00, 2'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0,
          8'hA5, 1'h1, 8'hA5, 1'h0},
        '{8'h3C, 8'h0F, 2'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1,
          8'h0F, 1'h1, 8'h00, 1'h1},
        '{8'hFF, 8'h81, 2'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0,
          8'h81, 1'h0, 8'h00, 1'h0},
        '{8'h96, 8'h00, 2'h0, 2'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1,
          8'h96, 1'h1, 8'h96, 1'h1},
        '{8'hC3, 8'h10, 2'h2, 2'h3, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0,
          8'hD3, 1'h1, 8'hC3, 1'h0},
        '{8'h5A, 8'h00, 2'h3, 2'h2, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0,
          8'h5A, 1'h1, 8'h00, 1'h0}
    };

    logic SYS_CLK = 1'h0;
    logic RESET_N = 1'h0;
    logic [DATA_W-1:0] CARD_DATA_IN = 8'h00;
    logic [DATA_W-1:0] OTHER_PULL = 8'h00; // Another card on the wire
    logic [1:0] RX_MODE = 2'h0;
    logic [1:0] TX_MODE = 2'h0;
    logic A2B_CLOCK_ENABLE = 1'h0;
    logic B2A_CLOCK_ENABLE = 1'h0;
    logic FEEDBACK_SELECT = 1'h0;
    logic A_OUT_ENABLE = 1'h0;
    logic B_OUT_ENABLE = 1'h0;
    logic B_OUT_ENABLE_LOW = 1'h1;
    logic EDGE_RATE_SELECT = 1'h0;
    logic CAPTURE_READY = 1'h0;
    logic CLK_EN = 1'h1; // Freezes the design while low
    logic [DATA_W-1:0] CARD_DATA_OUT, BP_DATA_OUT, BP_DATA_OE, BP_WIRE, CAPTURE_DATA;
    logic CARD_DATA_OUT_OE, EDGE_RATE_SLOW, CAPTURE_VALID, CAPTURE_SPACE;
    int fails = 0;
    int checks_done = 0;

    backplane_xcvr dut (
        .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
        .CARD_DATA_IN(CARD_DATA_IN), .CARD_DATA_OUT(CARD_DATA_OUT),
        .CARD_DATA_OUT_OE(CARD_DATA_OUT_OE), .BP_DATA_IN(BP_WIRE),
        .BP_DATA_OUT(BP_DATA_OUT), .BP_DATA_OE(BP_DATA_OE),
        .RX_MODE_SEL_HI(RX_MODE[1]), .RX_MODE_SEL_LO(RX_MODE[0]),
        .TX_MODE_SEL_HI(TX_MODE[1]), .TX_MODE_SEL_LO(TX_MODE[0]),
        .A2B_CLOCK_ENABLE(A2B_CLOCK_ENABLE), .B2A_CLOCK_ENABLE(B2A_CLOCK_ENABLE),
        .FEEDBACK_SELECT(FEEDBACK_SELECT), .A_OUT_ENABLE(A_OUT_ENABLE),
        .B_OUT_ENABLE(B_OUT_ENABLE), .B_OUT_ENABLE_LOW(B_OUT_ENABLE_LOW),
        .EDGE_RATE_SELECT(EDGE_RATE_SELECT), .EDGE_RATE_SLOW(EDGE_RATE_SLOW),
        .CAPTURE_DATA(CAPTURE_DATA), .CAPTURE_VALID(CAPTURE_VALID),
        .CAPTURE_READY(CAPTURE_READY), .CAPTURE_SPACE(CAPTURE_SPACE)
    );

    bp_bus_model #(.WIDTH(DATA_W)) bus (
        .drv_level(BP_DATA_OUT), .drv_oe(BP_DATA_OE),
        .other_pull(OTHER_PULL), .wire_level(BP_WIRE)
    );

    // Free-running 40 ns clock
    initial begin
        forever #20 SYS_CLK = ~SYS_CLK;
    end

    // Case-equality compare, so an unknown never passes
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Inputs always move 1 ns after a rising edge
    task automatic settle(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        int n;
        settle(20);
        RESET_N = 1'h1;
        // Table of static paths, every mode code but flip-flop 01 among them
        foreach (rows[i]) begin
            CARD_DATA_IN = rows[i].din;
            OTHER_PULL = rows[i].pull;
            TX_MODE = rows[i].txm;
            RX_MODE = rows[i].rxm;
            A2B_CLOCK_ENABLE = rows[i].a2b;
            B2A_CLOCK_ENABLE = rows[i].b2a;
            FEEDBACK_SELECT = rows[i].fb;
            A_OUT_ENABLE = rows[i].aoe;
            B_OUT_ENABLE = rows[i].boe;
            B_OUT_ENABLE_LOW = rows[i].boel;
            EDGE_RATE_SELECT = rows[i].ers;
            settle(LAT);
            check("card out", CARD_DATA_OUT, rows[i].dout);
            check("card oe", {7'h00, CARD_DATA_OUT_OE}, {7'h00, rows[i].oe});
            check("bp oe", BP_DATA_OE, rows[i].bpoe);
            check("bp level", BP_DATA_OUT, 8'h00);
            check("slow", {7'h00, EDGE_RATE_SLOW}, {7'h00, rows[i].slow});
        end

        // Flip-flop transmit takes data while the driver is off
        TX_MODE = 2'h1;
        A2B_CLOCK_ENABLE = 1'h0;
        B_OUT_ENABLE_LOW = 1'h0;
        FEEDBACK_SELECT = 1'h0;
        RX_MODE = 2'h0;
        CARD_DATA_IN = 8'h11;
        settle(LAT);
        A2B_CLOCK_ENABLE = 1'h1;
        settle(LAT);
        B_OUT_ENABLE = 1'h1;
        settle(LAT);
        check("ff capture", BP_DATA_OE, 8'h11);
        CARD_DATA_IN = 8'h22;
        settle(LAT);
        check("ff hold", BP_DATA_OE, 8'h11);
        A2B_CLOCK_ENABLE = 1'h0;
        settle(LAT);
        check("ff fall", BP_DATA_OE, 8'h11);
        A2B_CLOCK_ENABLE = 1'h1;
        settle(LAT);
        check("ff next", BP_DATA_OE, 8'h22);

        // Flip-flop receive fed from the transmit element with the wire ignored, then from the wire
        RX_MODE = 2'h1;
        B2A_CLOCK_ENABLE = 1'h0;
        FEEDBACK_SELECT = 1'h1;
        OTHER_PULL = 8'hFF;
        settle(LAT);
        B2A_CLOCK_ENABLE = 1'h1;
        settle(LAT);
        check("loop ff", CARD_DATA_OUT, 8'h22);
        FEEDBACK_SELECT = 1'h0;
        settle(LAT);
        check("rx hold", CARD_DATA_OUT, 8'h22);
        B2A_CLOCK_ENABLE = 1'h0;
        settle(LAT);
        B2A_CLOCK_ENABLE = 1'h1;
        settle(LAT);
        check("rx from wire", CARD_DATA_OUT, 8'hFF);

        // Latch closes, keeps its value while the driver is off
        TX_MODE = 2'h2;
        B_OUT_ENABLE = 1'h0;
        CARD_DATA_IN = 8'h44;
        settle(LAT);
        A2B_CLOCK_ENABLE = 1'h0;
        settle(LAT);
        CARD_DATA_IN = 8'h55;
        settle(LAT);
        B_OUT_ENABLE = 1'h1;
        settle(LAT);
        check("latch hold", BP_DATA_OE, 8'h44);
        A2B_CLOCK_ENABLE = 1'h1;
        settle(LAT);
        check("latch open", BP_DATA_OE, 8'h55);

        // History stream: empty it, overfill with a stalled consumer
        RX_MODE = 2'h0;
        B_OUT_ENABLE = 1'h0;
        OTHER_PULL = 8'h00;
        CAPTURE_READY = 1'h1;
        settle(3 * LAT);
        CAPTURE_READY = 1'h0;
        for (int k = 0; k < 10; k++) begin
            OTHER_PULL = 8'h10 + 8'(k);
            settle(8);
        end
        check("space full", {7'h00, CAPTURE_SPACE}, 8'h00);
        n = 0;
        // Bounded drain; a short count shows up as a mismatch
        for (int c = 0; c < 40; c++) begin
            if (CAPTURE_VALID === 1'h1) begin
                check("capture word", CAPTURE_DATA, ~(8'h10 + 8'(n)));
                n++;
            end
            CAPTURE_READY = 1'h1;
            settle(1);
        end
        check("capture count", 8'(n), 8'h09);
        check("space back", {7'h00, CAPTURE_SPACE}, 8'h01);

        // Clock enable low freezes the whole path; it moves again once raised
        CLK_EN = 1'h0;
        OTHER_PULL = 8'h00;
        settle(LAT);
        check("frozen", CARD_DATA_OUT, 8'h19);
        CLK_EN = 1'h1;
        settle(LAT);
        check("thawed", CARD_DATA_OUT, 8'h00);

        // Reset in mid-run clears stored data and releases the wire
        RESET_N = 1'h0;
        #5;
        check("reset card", CARD_DATA_OUT, 8'hFF);
        check("reset bp", BP_DATA_OE, 8'h00);
        settle(2);
        RESET_N = 1'h1;
        settle(LAT);
        check("after reset", BP_DATA_OE, 8'h00);
        results();
    end
endmodule
